// ===== pkg/crxf_defs.vh
// constants for the receive filter, linking and auto answer block
// Function
// - mask bit zero: incoming bit must equal code bit, else buffer rejects
// - mask bit one: incoming bit is ignored by the filter
// - filter covers identifier, ide, rtr and first two data bytes
// - standard 11-bit identifier sits at filter bits 31 down to 21
// - extended frames use a 29-bit identifier for filtering and answers
// - first two data bytes compared to data code where data mask is zero
// - full linked matching buffer continues search to next valid buffer
// - linked search finding no further buffer raises overrun flag
// - message into full unlinked buffer raises overrun event
// - remote frame has rtr one and no data, whatever dlc says
// - accepted remote request with auto answer set sends buffer content
// - answer pending set on request, cleared when sent or buffer disabled
// - per-buffer cancel command clears a pending automatic answer
// - whole block runs from one bus clock
// - search starts at buffer zero; valid means enabled and filter matches
// - storing sets message available; software clears it to free buffer
// - store into buffer with receive irq enable raises receive done flag
`ifndef CRXF_DEFS_VH
`define CRXF_DEFS_VH
// ============================================================
// frame layout
`define CRXF_NBUF        16
`define CRXF_ID_MSB      31
`define CRXF_STD_LSB     21
`define CRXF_EXT_LSB     3
`define CRXF_DATA_W      16
`define CRXF_FIFO_DEPTH  4
// ============================================================
// receive word fields: {id[31:3], ide, rtr, dlc[3:0], data[63:0]}
`define CRXF_MSG_W       99
`define CRXF_DATA_LSB    0
`define CRXF_DLC_LSB     64
`define CRXF_RTR_BIT     68
`define CRXF_IDE_BIT     69
`define CRXF_ID_LSB      70
// ============================================================
// filter word: {id[31:3], ide, rtr} matches 31:1 of mask and code
`define CRXF_FLT_W       31
`endif

// ===== testbench/crxf_can_node.sv
// far node model taking automatic answers after a set stall
`timescale 1ns/1ps
module crxf_can_node (
  input  wire       i_clk,
  input  wire       i_reset_n,
  input  wire       i_tx_valid,
  input  wire [7:0] i_wait,
  output reg        o_tx_ready,
  output reg  [7:0] o_got
);
  reg [7:0] cnt_q;
  // ============================================================
  // stall, then take one answer; even the largest wait only delays it
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_tx_ready <= 1'b0;
      cnt_q      <= 8'h0;
      o_got      <= 8'h0;
    end else if (i_tx_valid && o_tx_ready) begin
      o_tx_ready <= 1'b0;
      cnt_q      <= 8'h0;
      o_got      <= o_got + 8'h1;
    end else if (i_tx_valid && cnt_q >= i_wait) begin
      o_tx_ready <= 1'b1;
    end else begin
      o_tx_ready <= 1'b0;
      cnt_q      <= i_tx_valid ? cnt_q + 8'h1 : 8'h0;
    end
  end
endmodule // crxf_can_node

// ===== testbench/crxf_rx_filter_asserts.sv
// assertion checker on the receive filter block ports
`timescale 1ns/1ps
`include "crxf_defs.vh"
module crxf_rx_filter_asserts #(
  parameter NBUF = 16,
  parameter BW   = 4
) (
  input wire                   i_clk,
  input wire                   i_reset_n,
  input wire                   i_ce,
  input wire                   i_rx_valid,
  input wire                   o_rx_ready,
  input wire                   i_rx_rtr,
  input wire [NBUF-1:0]        i_buffer_enable,
  input wire [NBUF-1:0]        i_receive_irq_enable,
  input wire [NBUF-1:0]        i_auto_answer_cancel,
  input wire [NBUF-1:0]        o_message_available_flag,
  input wire [NBUF-1:0]        o_auto_answer_pending,
  input wire                   o_receive_done_irq,
  input wire                   o_receive_overrun_irq,
  input wire                   o_tx_valid,
  input wire                   i_tx_ready,
  input wire [`CRXF_MSG_W-1:0] o_tx_msg,
  input wire [BW-1:0]          o_tx_buf
);
  wire            take     = i_rx_valid & o_rx_ready & i_ce;
  wire            take_rtr = take & i_rx_rtr;
  wire [NBUF-1:0] mav      = o_message_available_flag;
  wire [NBUF-1:0] pnd      = o_auto_answer_pending;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // ============================================================
  // stores and flags, two cycles behind the taken frame
  a_store_cause: assert property (
    (mav & ~$past(mav)) != 0 |-> $past(take, 2)) else $error("flag set without frame");
  a_store_enabled: assert property (
    (mav & ~$past(mav) & ~$past(i_buffer_enable)) == 0) else $error("disabled buffer stored");
  a_done_enable: assert property (
    o_receive_done_irq |-> (mav & $past(i_receive_irq_enable)) != 0) else $error("stray done irq");
  a_loss_cause: assert property (
    o_receive_overrun_irq |-> $past(take, 2)) else $error("loss without frame");
  // ============================================================
  // automatic answers
  a_pend_cause: assert property (
    (pnd & ~$past(pnd)) != 0 |-> $past(take_rtr, 2)) else $error("pending without request");
  a_pend_cancel: assert property (
    (pnd & $past(i_auto_answer_cancel)) == 0) else $error("cancel ignored");
  a_tx_pending: assert property (
    o_tx_valid |-> pnd[o_tx_buf] && !o_tx_msg[`CRXF_RTR_BIT]) else $error("bad answer frame");
  a_tx_hold: assert property (
    o_tx_valid && !i_tx_ready |=> !o_tx_valid || ($stable(o_tx_msg) && $stable(o_tx_buf)))
    else $error("answer changed while stalled");
  c_loss: cover property (o_receive_overrun_irq);
  c_answer: cover property (o_tx_valid && i_tx_ready);
  c_stall: cover property (o_tx_valid && !i_tx_ready);
endmodule // crxf_rx_filter_asserts
bind crxf_rx_filter crxf_rx_filter_asserts #(.NBUF(NBUF), .BW(BW)) u_chk (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_ce(i_ce), .i_rx_valid(i_rx_valid),
  .o_rx_ready(o_rx_ready), .i_rx_rtr(i_rx_rtr), .i_buffer_enable(i_buffer_enable),
  .i_receive_irq_enable(i_receive_irq_enable), .i_auto_answer_cancel(i_auto_answer_cancel),
  .o_message_available_flag(o_message_available_flag),
  .o_auto_answer_pending(o_auto_answer_pending), .o_receive_done_irq(o_receive_done_irq),
  .o_receive_overrun_irq(o_receive_overrun_irq), .o_tx_valid(o_tx_valid),
  .i_tx_ready(i_tx_ready), .o_tx_msg(o_tx_msg), .o_tx_buf(o_tx_buf));

// ===== testbench/tb_top.sv
// self-checking bench for the receive filter block
`timescale 1ns/1ps
module tb_top;
  reg          i_clk, i_reset_n, i_ce, vld, ide, rtr;
  reg  [28:0]  id;
  reg  [63:0]  dat;
  reg  [511:0] fm, fc;
  reg  [255:0] dm, dc;
  reg  [15:0]  en, lnk, ien, aen, can, ack;
  reg  [3:0]   sel;
  reg  [7:0]   stall;
  wire         rdy, txv, txr, done, ovr;
  wire [15:0]  mav, pend;
  wire [98:0]  rd, txm;
  wire [3:0]   txb;
  wire [7:0]   got;
  integer      errors, total_checks, n_done, n_ovr, nd, k;
  crxf_rx_filter dut (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_ce(i_ce), .i_rx_valid(vld),
    .o_rx_ready(rdy), .i_rx_id(id), .i_rx_ide(ide), .i_rx_rtr(rtr), .i_rx_dlc(4'h2),
    .i_rx_data(dat), .i_filter_mask(fm), .i_filter_code(fc), .i_data_filter_mask(dm),
    .i_data_filter_code(dc), .i_buffer_enable(en), .i_link_flag(lnk),
    .i_receive_irq_enable(ien), .i_auto_answer_enable(aen), .i_auto_answer_cancel(can),
    .i_msg_ack(ack), .o_message_available_flag(mav), .o_auto_answer_pending(pend),
    .o_receive_done_irq(done), .o_receive_overrun_irq(ovr), .i_rd_sel(sel), .o_rd_msg(rd),
    .o_tx_valid(txv), .i_tx_ready(txr), .o_tx_msg(txm), .o_tx_buf(txb));
  crxf_can_node node (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_tx_valid(txv),
    .i_wait(stall), .o_tx_ready(txr), .o_got(got));
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    if (done === 1'b1) n_done = n_done + 1;
    if (ovr === 1'b1) n_ovr = n_ovr + 1;
  end
  // ============================================================
  // access tasks
  task finish_test;
    begin
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  task chk(input string nm, input [98:0] s, e);
    begin
      total_checks = total_checks + 1;
      if (s !== e) begin
        errors = errors + 1;
        $display("Error %0s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  task tick(input integer n);
    begin
      repeat (n) @(posedge i_clk);
      #1;
    end
  endtask
  task bound(input integer c);
    if (c > 60) begin
      errors = errors + 1;
      finish_test;
    end
  endtask
  // leaves valid high so frames can follow back to back
  task send(input [28:0] i, input e, r, input [15:0] d);
    begin
      id = i;
      ide = e;
      rtr = r;
      dat = {d, 48'h0};
      vld = 1'b1;
      k = 0;
      while (rdy !== 1'b1) begin
        tick(1);
        k = k + 1;
        bound(k);
      end
      tick(1);
    end
  endtask
  task frame(input [28:0] i, input e, r, input [15:0] d);
    begin
      send(i, e, r, d);
      vld = 1'b0;
      tick(3);
    end
  endtask
  task wait_answer;
    begin
      k = 0;
      while (!(txv === 1'b1 && txr === 1'b1)) begin
        tick(1);
        k = k + 1;
        bound(k);
      end
    end
  endtask
  task clr(input integer n);
    begin
      ack[n] = 1'b1;
      tick(1);
      ack[n] = 1'b0;
    end
  endtask
  task cfg(input integer n, input [31:0] m, c, input [15:0] x, y);
    begin
      fm[n*32+:32] = m;
      fc[n*32+:32] = c;
      dm[n*16+:16] = x;
      dc[n*16+:16] = y;
    end
  endtask
  // ============================================================
  // main sequence
  initial begin
    {i_reset_n, vld, ide, rtr, id, dat, can, ack, sel} = 0;
    i_ce = 1'b1;
    fm = {512{1'b1}};
    fc = 512'h0;
    dm = {256{1'b1}};
    dc = 256'h0;
    en = 16'h003f;
    lnk = 16'h0008;
    ien = 16'hfffd;
    aen = 16'h0020;
    stall = 8'h03;
    {errors, total_checks, n_done, n_ovr} = 0;
    cfg(0, 32'h601ffff8, {11'h182, 21'h0}, 16'hffff, 16'h0);
    cfg(1, 32'h0, {11'h0a5, 21'h0}, 16'h0, 16'h5aa5);
    cfg(2, 32'h0, {29'h0bcd1234, 3'h4}, 16'hffff, 16'h0);
    cfg(3, 32'h0, {11'h300, 21'h0}, 16'hffff, 16'h0);
    cfg(4, 32'h0, {11'h300, 21'h0}, 16'hffff, 16'h0);
    cfg(5, 32'h2, {11'h123, 21'h0}, 16'hffff, 16'h0);
    tick(20);
    i_reset_n = 1'b1;
    frame(29'h182, 0, 0, 16'h1111);
    chk("mav", mav, 16'h0001);
    chk("id", rd[98:70], 29'h182);
    chk("done", n_done, 1);
    clr(0);
    frame(29'h582, 0, 0, 16'h1111);
    chk("mav", mav, 16'h0);
    frame(29'h082, 0, 0, 16'h1111);
    chk("mav", mav, 16'h0001);
    frame(29'h182, 0, 0, 16'h2222);
    chk("data", rd[63:48], 16'h2222);
    chk("loss", n_ovr, 1);
    clr(0);
    nd = n_done;
    frame(29'h0a5, 0, 0, 16'h5aa4);
    frame(29'h0a5, 0, 0, 16'h5ba5);
    chk("mav", mav, 16'h0);
    frame(29'h0a5, 0, 0, 16'h5aa5);
    chk("mav", mav, 16'h0002);
    chk("done", n_done, nd);
    clr(1);
    sel = 4'h2;
    frame(29'h0bcd1234, 0, 0, 16'h0);
    chk("mav", mav, 16'h0);
    frame(29'h0bcd1234, 1, 0, 16'h0);
    chk("mav", mav, 16'h0004);
    chk("id", rd[98:70], 29'h0bcd1234);
    clr(2);
    sel = 4'h4;
    send(29'h300, 0, 0, 16'h0001);
    send(29'h300, 0, 0, 16'h0002);
    frame(29'h300, 0, 0, 16'h0003);
    chk("mav", mav, 16'h0018);
    chk("data", rd[63:48], 16'h0003);
    chk("loss", n_ovr, 2);
    // last member linked as well: the search runs out and the frame is dropped
    lnk = 16'h0018;
    frame(29'h300, 0, 0, 16'h0004);
    chk("loss", n_ovr, 3);
    chk("data", rd[63:48], 16'h0003);
    lnk = 16'h0008;
    clr(3);
    clr(4);
    sel = 4'h5;
    frame(29'h123, 0, 1, 16'hbeef);
    chk("pend", pend, 16'h0020);
    wait_answer;
    chk("txid", txm[98:70], 29'h123);
    chk("txbuf", txb, 4'h5);
    tick(2);
    chk("pend", pend, 16'h0);
    chk("mav", mav, 16'h0020);
    chk("rdata", rd[63:0], 64'h0);
    clr(5);
    stall = 8'hff;
    frame(29'h123, 0, 1, 16'h0);
    can = 16'h0020;
    tick(1);
    can = 16'h0;
    tick(2);
    chk("pend", pend, 16'h0);
    chk("txv", txv, 1'b0);
    clr(5);
    frame(29'h123, 0, 1, 16'h0);
    en = 16'h001f;
    tick(2);
    chk("pend", pend, 16'h0);
    chk("got", got, 8'h1);
    // extended remote request, ide and rtr left open in buffer five
    en = 16'h003f;
    stall = 8'h03;
    fm[191:160] = 32'h00000006;
    clr(5);
    frame(29'h048c0000, 1, 1, 16'h0);
    wait_answer;
    chk("txide", txm[69], 1'b1);
    chk("txid", txm[98:70], 29'h048c0000);
    chk("txrtr", txm[68], 1'b0);
    tick(2);
    // no auto answer: request is only stored for software to handle
    aen = 16'h0;
    clr(5);
    frame(29'h123, 0, 1, 16'h0);
    chk("pend", pend, 16'h0);
    chk("mav", mav, 16'h0020);
    i_ce = 1'b0;
    clr(5);
    chk("mav", mav, 16'h0020);
    i_ce = 1'b1;
    clr(5);
    chk("mav", mav, 16'h0);
    finish_test;
  end
endmodule // tb_top

// ===== verilog/crxf_fifo.v
// small valid/ready fifo buffering received frames before the search
`timescale 1ns/1ps
module crxf_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             i_clk,
  input  wire             i_reset_n,
  input  wire             i_ce,
  input  wire             i_in_valid,
  output wire             o_in_ready,
  input  wire [WIDTH-1:0] i_in_data,
  output wire             o_out_valid,
  input  wire             i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;

  assign o_in_ready  = (cnt_q != DEPTH[AW:0]);
  assign o_out_valid = (cnt_q != {(AW+1){1'b0}});
  assign o_out_data  = mem_q[rd_q];
  assign push = i_ce & i_in_valid & o_in_ready;
  assign pop  = i_ce & o_out_valid & i_out_ready;

  // ============================================================
  // storage and pointers
  always @(posedge i_clk) begin
    if (push) begin
      mem_q[wr_q] <= i_in_data;
    end
  end

  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // crxf_fifo

// ===== verilog/crxf_rx_filter.v
// receive buffer search, acceptance filtering, linking and automatic remote answers
`timescale 1ns/1ps
`include "crxf_defs.vh"
module crxf_rx_filter #(
  parameter NBUF = `CRXF_NBUF,
  parameter BW   = 4
) (
  input  wire                       i_clk,
  input  wire                       i_reset_n,
  input  wire                       i_ce,
  // framer side: one received frame per handshake
  input  wire                       i_rx_valid,
  output wire                       o_rx_ready,
  input  wire [28:0]                i_rx_id,
  input  wire                       i_rx_ide,
  input  wire                       i_rx_rtr,
  input  wire [3:0]                 i_rx_dlc,
  input  wire [63:0]                i_rx_data,
  // per-buffer configuration, flattened buffer n at [n*w +: w]
  input  wire [NBUF*32-1:0]         i_filter_mask,
  input  wire [NBUF*32-1:0]         i_filter_code,
  input  wire [NBUF*16-1:0]         i_data_filter_mask,
  input  wire [NBUF*16-1:0]         i_data_filter_code,
  input  wire [NBUF-1:0]            i_buffer_enable,
  input  wire [NBUF-1:0]            i_link_flag,
  input  wire [NBUF-1:0]            i_receive_irq_enable,
  input  wire [NBUF-1:0]            i_auto_answer_enable,
  input  wire [NBUF-1:0]            i_auto_answer_cancel,
  input  wire [NBUF-1:0]            i_msg_ack,
  // status
  output reg  [NBUF-1:0]            o_message_available_flag,
  output reg  [NBUF-1:0]            o_auto_answer_pending,
  output reg                        o_receive_done_irq,
  output reg                        o_receive_overrun_irq,
  // stored content of one buffer, selected for reading
  input  wire [BW-1:0]              i_rd_sel,
  output reg  [`CRXF_MSG_W-1:0]     o_rd_msg,
  // automatic answer transmit request
  output wire                       o_tx_valid,
  input  wire                       i_tx_ready,
  output reg  [`CRXF_MSG_W-1:0]     o_tx_msg,
  output reg  [BW-1:0]              o_tx_buf
);
  // ============================================================
  // declarations
  reg  [`CRXF_MSG_W-1:0] store_q [0:NBUF-1];
  reg                    tx_busy_q;
  wire [`CRXF_MSG_W-1:0] in_word;
  wire                   f_valid;
  wire [`CRXF_MSG_W-1:0] f_word;
  wire                   f_take;
  reg  [NBUF-1:0]        match;
  reg  [NBUF-1:0]        mav_d;
  reg  [NBUF-1:0]        pnd_d;
  reg                    found;
  reg                    stop;
  reg                    lost;
  reg  [BW-1:0]          tgt;
  reg  [BW-1:0]          ans_sel;
  reg                    ans_found;
  // one loop variable per process, so no process wakes another through it
  integer                mi;
  integer                si;
  integer                ai;

  // remote frames carry no data field whatever the dlc holds
  assign in_word = {i_rx_id, i_rx_ide, i_rx_rtr, i_rx_dlc,
                    i_rx_rtr ? 64'h0000000000000000 : i_rx_data};

  // ============================================================
  // input fifo; a full fifo stalls the framer
  crxf_fifo #(
    .WIDTH (`CRXF_MSG_W),
    .DEPTH (`CRXF_FIFO_DEPTH),
    .AW    (2)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_reset_n   (i_reset_n),
    .i_ce        (i_ce),
    .i_in_valid  (i_rx_valid),
    .o_in_ready  (o_rx_ready),
    .i_in_data   (in_word),
    .o_out_valid (f_valid),
    .i_out_ready (1'b1),
    .o_out_data  (f_word)
  );
  assign f_take = i_ce & f_valid;

  // ============================================================
  // acceptance filter of one buffer
  function flt_match;
    input [`CRXF_MSG_W-1:0] w;
    input [31:0]            msk;
    input [31:0]            cod;
    input [15:0]            dmsk;
    input [15:0]            dcod;
    reg   [31:0]            fld;
    reg   [15:0]            dat;
    begin
      // standard ids land in 31:21, extended ids fill 31:3
      if (w[`CRXF_IDE_BIT]) begin
        fld = {w[`CRXF_ID_LSB +: 29], w[`CRXF_IDE_BIT], w[`CRXF_RTR_BIT], 1'b0};
      end else begin
        fld = {w[`CRXF_ID_LSB +: 11], 18'h00000, w[`CRXF_IDE_BIT],
               w[`CRXF_RTR_BIT], 1'b0};
      end
      // byte one is data[63:56], byte two data[55:48]
      dat = w[`CRXF_DATA_LSB + 48 +: 16];
      // zero mask bits must match the code, one bits are ignored
      flt_match = ((((fld ^ cod) & ~msk) & 32'hfffffffe) == 32'h00000000) &&
                  (((dat ^ dcod) & ~dmsk) == 16'h0000);
    end
  endfunction

  always @* begin
    for (mi = 0; mi < NBUF; mi = mi + 1) begin
      match[mi] = i_buffer_enable[mi] &
                  flt_match(f_word, i_filter_mask[mi*32 +: 32], i_filter_code[mi*32 +: 32],
                            i_data_filter_mask[mi*16 +: 16],
                            i_data_filter_code[mi*16 +: 16]);
    end
  end

  // ============================================================
  // receive buffer search, lowest index first
  always @* begin
    found = 1'b0;
    stop  = 1'b0;
    lost  = 1'b0;
    tgt   = {BW{1'b0}};
    for (si = 0; si < NBUF; si = si + 1) begin
      if (!stop && match[si]) begin
        if (!o_message_available_flag[si]) begin
          found = 1'b1;
          stop  = 1'b1;
          tgt   = si[BW-1:0];
        end else if (!i_link_flag[si]) begin
          // full and unlinked: overwrite and report the loss
          found = 1'b1;
          lost  = 1'b1;
          stop  = 1'b1;
          tgt   = si[BW-1:0];
        end
        // full and linked: keep searching
      end
    end
    if (!stop && (match != {NBUF{1'b0}})) begin
      // only full linked buffers matched; frame dropped
      lost = 1'b1;
    end
  end

  // ============================================================
  // storage of the frame
  always @(posedge i_clk) begin
    if (f_take && found) begin
      store_q[tgt] <= f_word;
    end
  end

  always @* begin
    o_rd_msg = store_q[i_rd_sel];
  end

  // ============================================================
  // flags; hardware set wins over software clear
  always @* begin
    mav_d = o_message_available_flag & ~i_msg_ack;
    pnd_d = o_auto_answer_pending & ~i_auto_answer_cancel & i_buffer_enable;
    if (o_tx_valid && i_tx_ready) begin
      pnd_d[o_tx_buf] = 1'b0;
    end
    if (f_take && found) begin
      // the stored request stays visible when it is answered
      mav_d[tgt] = 1'b1;
      if (f_word[`CRXF_RTR_BIT] && i_auto_answer_enable[tgt]) begin
        pnd_d[tgt] = 1'b1;
      end
    end
  end

  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_message_available_flag <= {NBUF{1'b0}};
      o_auto_answer_pending    <= {NBUF{1'b0}};
      o_receive_done_irq       <= 1'b0;
      o_receive_overrun_irq    <= 1'b0;
    end else if (i_ce) begin
      o_message_available_flag <= mav_d;
      o_auto_answer_pending    <= pnd_d;
      o_receive_done_irq       <= f_take & found & i_receive_irq_enable[tgt];
      o_receive_overrun_irq    <= f_take & lost;
    end
  end

  // ============================================================
  // automatic answer: lowest pending buffer, sent with its stored identifier
  always @* begin
    ans_found = 1'b0;
    ans_sel   = {BW{1'b0}};
    for (ai = NBUF - 1; ai >= 0; ai = ai - 1) begin
      if (o_auto_answer_pending[ai]) begin
        ans_found = 1'b1;
        ans_sel   = ai[BW-1:0];
      end
    end
  end

  // request stands until taken; a cancel or disable withdraws it next cycle
  assign o_tx_valid = tx_busy_q & o_auto_answer_pending[o_tx_buf];

  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tx_busy_q <= 1'b0;
      o_tx_buf  <= {BW{1'b0}};
      o_tx_msg  <= {`CRXF_MSG_W{1'b0}};
    end else if (i_ce) begin
      if (tx_busy_q && (!o_auto_answer_pending[o_tx_buf] || i_tx_ready)) begin
        tx_busy_q <= 1'b0;
      end else if (!tx_busy_q && ans_found) begin
        tx_busy_q <= 1'b1;
        o_tx_buf  <= ans_sel;
        // answer is a data frame with the same identifier
        o_tx_msg  <= store_q[ans_sel] & ~({{(`CRXF_MSG_W-`CRXF_RTR_BIT-1){1'b0}}, 1'b1,
                     {`CRXF_RTR_BIT{1'b0}}});
      end
    end
  end
endmodule // crxf_rx_filter
